// >>> ddr_memory_model.sv
// Behavioural memory side driving the read strobe
`timescale 1ns/1ps
`default_nettype none
module ddr_memory_model (
    output logic strobe
);
    logic drive = 1'b0;
    logic level = 1'b0;
    // Released line pulled high by termination
    assign strobe = drive ? level : 1'b1;
    // Low preamble, 160 ns beats, release
    task automatic burst(input int preHalves, input int beats);
        drive = 1'b1;
        level = 1'b0;
        #(80 * preHalves);
        repeat (beats) begin
            level = 1'b1;
            #80;
            level = 1'b0;
            #80;
        end
        drive = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> ddr_strobe_io_control.sv
// Strobe group tristate, ISI, read and write strobe control
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Single-rate and plain DDR register tristate input in one flop driving enable.
// RULE2: Double-gear passes registered tristate through a phase-clocked second register.
// RULE3: ISI correction only in double-gear, one setting per output pin.
// RULE4: Stretch isolated bit of 010 or 101; no stretch between long runs.
// RULE5: Stretch amount is a 3-bit delay field in the control block.
// RULE6: Twelve cells per group, two of them usable as strobe and complement.
// RULE7: Top edge has no output gearing, so double-gear modes are blocked.
// RULE8: Bottom edge supports neither memory nor generic DDR.
// RULE9: DLL tracks PVT from system clock feedback, emits a 7-bit code; here the reference is the measured read strobe period.
// RULE10: Left DLL serves banks 0, 7, 6; right DLL banks 1, 2, 3.
// RULE11: Read strobe delayed 90 degrees by DLL code, fanned to data pins.
// RULE12: Read logic produces polarity picking the synchroniser clock edge.
// RULE13: Double-gear read makes transfer latch, first to second capture set.
// RULE14: Write logic makes two phase clocks for data and strobe gearing.
// RULE15: Write-level delay 8 bits: 128 steps over DLL code, top bit inverts.
// RULE16: Polarity is re-evaluated at the start of every read.
// RULE17: Memory leaves strobe tristated then drives it low for preamble.
// RULE18: First rising strobe edge after preamble sets the polarity.
// RULE19: Fabric controller performs write levelling, one delay per group.
// RULE20: Groups sized for ten data bits per strobe.
// RULE21: Each low step about 25 ps; value may come from static setting.
// RULE22: Capture-valid flag raised when captured input data is valid.
// RULE23: Polarity held steady until the read burst ends.
// RULE24: Reset clears tristate, gearing and polarity with outputs disabled.
module ddr_strobe_io_control
    import ddr_strobe_pkg::*;
#(
    parameter int              PINS       = DQ_PINS, // RULE20
    parameter int              STROBE_BANK = 2,
    parameter int              TAP_DEPTH  = 16,
    parameter int              DLL_UPDATE = DLL_UPDATE_CYC,
    parameter logic [WL_W-1:0] WL_STATIC  = 8'h00
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Avalon-MM slave
    input  wire logic [4:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Core side
    input  wire logic                  tristate_ctrl_in,
    input  wire logic [PINS-1:0]       coreDataOut,
    input  wire logic                  readActive,
    output logic      [PINS-1:0]       padDataOut,
    output logic      [PINS-1:0]       padOe,
    output logic      [PINS*ISI_W-1:0] isiStretch,
    output logic                       sync_clock_polarity,
    output logic                       gearbox_transfer_latch,
    output logic                       capture_valid_flag,
    output logic                       delayed_read_strobe_clk,
    output logic                       write_phase_clk_a,
    output logic                       write_phase_clk_b,
    output logic      [DLL_W-1:0]      dll_delay_code,
    output logic      [WL_W-1:0]       writeStrobeDelay,
    // Strobe pin pair
    input  wire logic                  strobeIn,
    output logic                       strobeOut,
    output logic                       strobeNOut,
    output logic                       strobeOe
);
    localparam int TAP_W = $clog2(TAP_DEPTH);

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic [1:0] rstSync_r;
    logic       rstN;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) rstSync_r <= 2'h0;
        else       rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstN = rstSync_r[1];

    // ------------------------------------------------------------
    // Register file over Avalon-MM
    // ------------------------------------------------------------
    logic [31:0]     ctrl_r;
    logic [31:0]     isi_r;
    logic [WL_W-1:0] wl_r;
    logic            ack_r;
    logic            access;
    logic            doWrite;
    logic [31:0]     statusWord;
    logic [31:0]     readMux;

    assign access          = avs_read || avs_write;
    assign avs_waitrequest = access && !ack_r;
    assign doWrite         = avs_write && ack_r;

    // Read data loaded a cycle early to stand at the acknowledge
    assign readMux = (avs_address == OFF_CTRL)   ? ctrl_r :
                     (avs_address == OFF_ISI)    ? isi_r :
                     (avs_address == OFF_WLDLY)  ? {24'h0, wl_r} :
                     (avs_address == OFF_STATUS) ? statusWord : 32'h0;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack_r <= access && !ack_r;
            if (avs_read && !ack_r) avs_readdata <= readMux;
        end
    end

    // Writes land on the edge where waitrequest is low
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrl_r <= CTRL_RST;
            isi_r  <= ISI_RST;
            wl_r   <= WL_RST;
        end else if (doWrite) begin
            if (avs_address == OFF_CTRL)  ctrl_r <= avs_writedata;
            if (avs_address == OFF_ISI)   isi_r  <= avs_writedata;
            if (avs_address == OFF_WLDLY) wl_r   <= avs_writedata[WL_W-1:0]; // RULE19
        end
    end

    // ------------------------------------------------------------
    // Mode decode by edge capability
    // ------------------------------------------------------------
    io_mode_type reqMode;
    edge_type    edgeSel;
    logic        gearOn;
    logic        ddrOn;

    assign reqMode = io_mode_type'(ctrl_r[CTRL_MODE_LO +: 2]);
    assign edgeSel = edge_type'(ctrl_r[CTRL_EDGE_LO +: 2]);
    // Top edge lacks output gearing; bottom edge lacks any DDR
    assign gearOn  = (reqMode == MODE_GEAR) && (edgeSel == EDGE_LEFT || edgeSel == EDGE_RIGHT); // RULE7
    assign ddrOn   = (reqMode != MODE_SDR) && (edgeSel != EDGE_BOTTOM); // RULE8

    // Banks 0, 7, 6 belong to the left DLL, all others to the right
    function automatic logic dllSideIsRight(input int bank);
        dllSideIsRight = !(bank == 0 || bank == 7 || bank == 6); // RULE10
    endfunction

    // ------------------------------------------------------------
    // Write phase clocks
    // ------------------------------------------------------------
    // Quadrature pair from clk, one domain
    logic [1:0] phaseCnt_r;
    logic       phaseBRise;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            phaseCnt_r        <= 2'h0;
            write_phase_clk_a <= 1'b0;
            write_phase_clk_b <= 1'b0;
        end else begin
            phaseCnt_r        <= phaseCnt_r + 2'h1;
            write_phase_clk_a <= phaseCnt_r[1]; // RULE14
            write_phase_clk_b <= phaseCnt_r[1] ^ phaseCnt_r[0]; // RULE14
        end
    end
    assign phaseBRise = (phaseCnt_r[1] ^ phaseCnt_r[0]) && !write_phase_clk_b;

    // ------------------------------------------------------------
    // Tristate path
    // ------------------------------------------------------------
    logic tsReg_r;
    logic tsGear_r;
    logic tsEff;

    // Reset tristates so no pad drives before setup
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            tsReg_r  <= 1'b1; // RULE24
            tsGear_r <= 1'b1; // RULE24
        end else begin
            tsReg_r <= tristate_ctrl_in; // RULE1
            if (phaseBRise || (phaseCnt_r == 2'h0)) tsGear_r <= tsReg_r; // RULE2
        end
    end
    assign tsEff = gearOn ? tsGear_r : tsReg_r; // RULE1 RULE2

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            padOe    <= '0;
            strobeOe <= 1'b0;
        end else begin
            padOe    <= {PINS{!tsEff}};
            strobeOe <= !tsEff;
        end
    end

    // ------------------------------------------------------------
    // ISI correction, one instance per data pin
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_isi
            isi_stretch u_isi (
                .clk      (clk),
                .rstN     (rstN),
                .enable   (gearOn), // RULE3
                .delaySel (isi_r[gi*ISI_W +: ISI_W]), // RULE3 RULE5
                .dataIn   (coreDataOut[gi]),
                .dataOut  (padDataOut[gi]),
                .stretch  (isiStretch[gi*ISI_W +: ISI_W])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Strobe pin sampling and period measurement
    // ------------------------------------------------------------
    logic [1:0] strobeSync_r;
    logic       strobePrev_r;
    logic       strobeRise;
    logic [6:0] periodCnt_r;
    logic [6:0] period_r;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            strobeSync_r <= 2'h3; // Idle line is pulled high: no false rise after reset
            strobePrev_r <= 1'b1;
        end else begin
            strobeSync_r <= {strobeSync_r[0], strobeIn};
            strobePrev_r <= strobeSync_r[1];
        end
    end
    assign strobeRise = strobeSync_r[1] && !strobePrev_r;

    // Period is the DLL reference; saturates when idle
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            periodCnt_r <= 7'h0;
            period_r    <= 7'h0;
        end else if (strobeRise) begin
            periodCnt_r <= 7'h1;
            period_r    <= periodCnt_r;
        end else if (periodCnt_r != 7'h7f) begin
            periodCnt_r <= periodCnt_r + 7'h1;
        end
    end

    // ------------------------------------------------------------
    // DLL loop: code steps toward a quarter period
    // ------------------------------------------------------------
    logic [DLL_W-1:0] target;
    logic [15:0]      dllTick_r;

    assign target = 7'((32'(period_r) * PHASE_DEG) / FULL_DEG); // RULE11

    // One step per update avoids code jumps
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            dllTick_r      <= 16'h0;
            dll_delay_code <= '0;
        end else if (dllTick_r == 16'(DLL_UPDATE - 1)) begin
            dllTick_r <= 16'h0;
            if (dll_delay_code < target)      dll_delay_code <= dll_delay_code + 7'h1; // RULE9
            else if (dll_delay_code > target) dll_delay_code <= dll_delay_code - 7'h1; // RULE9
        end else begin
            dllTick_r <= dllTick_r + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // Delayed read strobe
    // ------------------------------------------------------------
    logic [TAP_DEPTH-1:0] tapLine_r;
    logic [TAP_W-1:0]     tapSel;
    logic                 dlyPrev_r;
    logic                 dlyRise;
    logic                 dlyFall;

    // Taps past the line clamp to the last
    assign tapSel = (dll_delay_code > 7'(TAP_DEPTH - 1)) ? TAP_W'(TAP_DEPTH - 1)
                                                        : dll_delay_code[TAP_W-1:0];

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            tapLine_r               <= '0;
            delayed_read_strobe_clk <= 1'b0;
            dlyPrev_r               <= 1'b0;
        end else begin
            tapLine_r               <= {tapLine_r[TAP_DEPTH-2:0], strobeSync_r[1]};
            delayed_read_strobe_clk <= ddrOn && tapLine_r[tapSel]; // RULE11
            dlyPrev_r               <= delayed_read_strobe_clk;
        end
    end
    assign dlyRise = delayed_read_strobe_clk && !dlyPrev_r;
    assign dlyFall = !delayed_read_strobe_clk && dlyPrev_r;

    // ------------------------------------------------------------
    // Read burst and polarity control
    // ------------------------------------------------------------
    rd_state_type rdState_r;
    rd_state_type rdNxt;
    logic [1:0]   readSync_r;
    logic         latchPhase_r;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) readSync_r <= 2'h0;
        else       readSync_r <= {readSync_r[0], readActive};
    end

    // Await driven-low preamble, then first rise
    always_comb begin
        rdNxt = rdState_r;
        case (rdState_r)
            RD_IDLE:     if (readSync_r[1] && ddrOn) rdNxt = RD_WAIT_LOW;
            RD_WAIT_LOW: if (!strobeSync_r[1]) rdNxt = RD_PREAMBLE; // RULE17
            RD_PREAMBLE: if (strobeRise) rdNxt = RD_BURST; // RULE18
            RD_BURST:    rdNxt = RD_BURST;
            default:     rdNxt = RD_IDLE;
        endcase
        if (!readSync_r[1]) rdNxt = RD_IDLE;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) rdState_r <= RD_IDLE;
        else       rdState_r <= rdNxt;
    end

    // Polarity loads only at preamble exit
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            sync_clock_polarity <= 1'b0; // RULE24
        end else if (rdState_r == RD_PREAMBLE && strobeRise) begin
            sync_clock_polarity <= phaseCnt_r[0]; // RULE12 RULE16 RULE18
        end
    end
    // Outside the preamble exit the polarity flop never loads: RULE23

    // In double-gear, latch on every second delayed rise; valid on each fall
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            latchPhase_r           <= 1'b0;
            gearbox_transfer_latch <= 1'b0;
            capture_valid_flag     <= 1'b0;
        end else begin
            if (rdState_r != RD_BURST) latchPhase_r <= 1'b0;
            else if (dlyRise)          latchPhase_r <= !latchPhase_r;
            gearbox_transfer_latch <= gearOn && (rdState_r == RD_BURST) && dlyRise && latchPhase_r; // RULE13
            capture_valid_flag     <= (rdState_r == RD_BURST) && dlyFall; // RULE22
        end
    end

    // ------------------------------------------------------------
    // Write levelling and write strobe
    // ------------------------------------------------------------
    logic [WL_W-1:0] wlSel;

    assign wlSel = ctrl_r[CTRL_WLSTAT] ? WL_STATIC : wl_r; // RULE21

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            writeStrobeDelay <= '0;
            strobeOut        <= 1'b0;
            strobeNOut       <= 1'b1;
        end else begin
            writeStrobeDelay <= {1'b0, wlSel[WL_W-2:0] + dll_delay_code}; // RULE15 RULE21
            strobeOut        <= write_phase_clk_a ^ wlSel[WL_INVERT_BIT]; // RULE15
            strobeNOut       <= !(write_phase_clk_a ^ wlSel[WL_INVERT_BIT]); // RULE6
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    assign statusWord = {8'h0, writeStrobeDelay, 1'b0, dll_delay_code, 5'h0,
                         dllSideIsRight(STROBE_BANK), rdState_r == RD_BURST, sync_clock_polarity};
endmodule
`default_nettype wire

// >>> ddr_strobe_io_control_props.sv
// Port assertions for the strobe group block
`timescale 1ns/1ps
`default_nettype none
module ddr_strobe_io_control_props
    import ddr_strobe_pkg::*;
#(
    parameter int PINS = DQ_PINS
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic             avs_waitrequest,
    input  wire logic             readActive,
    input  wire logic [PINS-1:0]  padOe,
    input  wire logic             strobeOe,
    input  wire logic             strobeOut,
    input  wire logic             strobeNOut,
    input  wire logic             sync_clock_polarity,
    input  wire logic             gearbox_transfer_latch,
    input  wire logic             capture_valid_flag,
    input  wire logic             write_phase_clk_a,
    input  wire logic             write_phase_clk_b,
    input  wire logic [DLL_W-1:0] dll_delay_code
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_wait_first: assert property (($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest)
        else $error("no first wait");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    a_oe_shared: assert property (padOe == {PINS{strobeOe}})
        else $error("enable mismatch");
    a_strobe_pair: assert property (strobeNOut == !strobeOut)
        else $error("pair not inverse");
    a_phase_lead: assert property ($rose(write_phase_clk_b) |=> $rose(write_phase_clk_a))
        else $error("phase order");
    a_phase_period: assert property ($rose(write_phase_clk_a) |-> ##4 $rose(write_phase_clk_a))
        else $error("phase period");
    a_latch_pulse: assert property (gearbox_transfer_latch |=> !gearbox_transfer_latch)
        else $error("latch too wide");
    a_valid_pulse: assert property (capture_valid_flag |=> !capture_valid_flag)
        else $error("valid too wide");
    a_pol_hold: assert property ($changed(sync_clock_polarity) |-> $past(readActive, 2) || $past(readActive, 3))
        else $error("polarity moved");
    a_dll_step: assert property ($changed(dll_delay_code) |->
        dll_delay_code == $past(dll_delay_code) + 7'h01 || dll_delay_code == $past(dll_delay_code) - 7'h01)
        else $error("code jumped");
    c_valid: cover property ($rose(capture_valid_flag));
    c_latch: cover property ($rose(gearbox_transfer_latch));
    c_pol: cover property ($changed(sync_clock_polarity));
endmodule
bind ddr_strobe_io_control ddr_strobe_io_control_props #(.PINS(PINS)) u_props (.*);
`default_nettype wire

// >>> ddr_strobe_io_control_test.sv
// Self-checking bench for the strobe group control block
`timescale 1ns/1ps
`default_nettype none
module ddr_strobe_io_control_test;
    import ddr_strobe_pkg::*;
    localparam int PINS = DQ_PINS;
    logic [4:0]            avs_address;
    logic [31:0]           avs_writedata, avs_readdata, rd, wl;
    logic [PINS-1:0]       coreDataOut, padDataOut, padOe;
    logic [PINS*ISI_W-1:0] isiStretch;
    logic [DLL_W-1:0]      dll_delay_code;
    logic [WL_W-1:0]       writeStrobeDelay;
    logic                  clk, nrst, avs_read, avs_write, avs_waitrequest, tristate_ctrl_in, readActive;
    logic                  strobeIn, gearbox_transfer_latch, capture_valid_flag, pipeOn;
    logic [31:0]           seed = 32'habfb;
    logic [PINS:0]         pipe[$];
    int                    mismatches, n_tests, cycles, nValid, nLatch;
    ddr_strobe_io_control #(.DLL_UPDATE(1), .WL_STATIC(8'h03)) DUT (.clk(clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tristate_ctrl_in(tristate_ctrl_in),
        .coreDataOut(coreDataOut), .readActive(readActive), .padDataOut(padDataOut), .padOe(padOe),
        .isiStretch(isiStretch), .sync_clock_polarity(), .gearbox_transfer_latch(gearbox_transfer_latch),
        .capture_valid_flag(capture_valid_flag), .delayed_read_strobe_clk(), .write_phase_clk_a(),
        .write_phase_clk_b(), .dll_delay_code(dll_delay_code), .writeStrobeDelay(writeStrobeDelay),
        .strobeIn(strobeIn), .strobeOut(), .strobeNOut(), .strobeOe());
    ddr_memory_model MEM (.strobe(strobeIn));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        @(posedge clk);
        if (n == 50) mismatches++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // One read burst; vf, lf scale expected pulses
    task automatic readScen(input logic [3:0] ctrl, input int vf, input int lf);
        bus(1'b1, OFF_CTRL, {28'h0, ctrl});
        readActive <= 1'b1;
        repeat (6) @(posedge clk);
        seed = xs(seed);
        #(seed[3:0]);
        nValid = 0;
        nLatch = 0;
        MEM.burst(1 + seed[5:4], 8);
        repeat (12) @(posedge clk);
        readActive <= 1'b0;
        repeat (4) @(posedge clk);
        check(nValid, vf * 8);
        check(nLatch, lf * 4);
    endtask
    // ----------------------------------------
    // Clock, model, timeout
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Model: pads follow core inputs two clocks later
    always @(posedge clk) begin
        cycles++;
        nValid += (capture_valid_flag === 1'b1);
        nLatch += (gearbox_transfer_latch === 1'b1);
        if (pipeOn) begin
            pipe.push_back({tristate_ctrl_in, coreDataOut});
            if (pipe.size() == 3) begin
                check(padOe, {PINS{~pipe[0][PINS]}});
                check(padDataOut, pipe[0][PINS-1:0]);
                check(isiStretch, '0);
                void'(pipe.pop_front());
            end
            seed = xs(seed);
            tristate_ctrl_in <= seed[0];
            coreDataOut <= seed[PINS:1];
        end else pipe.delete();
        if (cycles == 30000) begin
            mismatches++;
            conclude();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {avs_address, avs_writedata, avs_read, avs_write, coreDataOut, readActive, pipeOn} = '0;
        tristate_ctrl_in = 1'b1;
        nrst = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 5'(i == 3 ? 16 : 4 * i), 32'h0);
            check(rd, 32'h0);
        end
        wl = xs(seed) & 32'h3fff_ffff;
        bus(1'b1, OFF_ISI, wl);
        bus(1'b0, OFF_ISI, 32'h0);
        check(rd, wl);
        bus(1'b1, 5'h10, 32'hffff_ffff);
        bus(1'b0, 5'h10, 32'h0);
        check(rd, 32'h0);
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, OFF_CTRL, m);
            pipeOn <= 1'b1;
            repeat (40) @(posedge clk);
            pipeOn <= 1'b0;
        end
        readScen({EDGE_LEFT, MODE_DDR}, 1, 0);
        readScen({EDGE_RIGHT, MODE_GEAR}, 1, 1);
        readScen({EDGE_BOTTOM, MODE_DDR}, 0, 0);
        readScen({EDGE_LEFT, MODE_SDR}, 0, 0);
        readScen({EDGE_LEFT, MODE_GEAR}, 1, 1);
        check(dll_delay_code, 7'd2);
        bus(1'b1, OFF_WLDLY, 32'h85);
        bus(1'b0, OFF_WLDLY, 32'h0);
        check(rd, 32'h85);
        repeat (3) @(posedge clk);
        check(writeStrobeDelay, 8'h07);
        bus(1'b1, OFF_CTRL, 32'h10);
        repeat (3) @(posedge clk);
        check(writeStrobeDelay, 8'h05);
        conclude();
    end
endmodule
`default_nettype wire

// >>> ddr_strobe_pkg.sv
// Shared constants and types for the strobe group I/O control
package ddr_strobe_pkg;
    // ------------------------------------------------------------
    // Group geometry
    // ------------------------------------------------------------
    localparam int CELLS_PER_GROUP = 12;
    localparam int STROBE_CELLS    = 2;
    localparam int DQ_PINS         = 10;
    localparam int ISI_W           = 3;
    localparam int DLL_W           = 7;
    localparam int WL_W            = 8;
    localparam int WL_INVERT_BIT   = 7;
    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_ISI    = 5'h04;
    localparam logic [4:0] OFF_WLDLY  = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0c;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] ISI_RST   = 32'h0000_0000;
    localparam logic [7:0]  WL_RST    = 8'h00;
    // CTRL fields
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_EDGE_LO = 2;
    localparam int CTRL_WLSTAT  = 4;
    // STATUS fields
    localparam int ST_POL   = 0;
    localparam int ST_BURST = 1;
    localparam int ST_SIDE  = 2;
    localparam int ST_DLL   = 8;
    localparam int ST_WLEFF = 16;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 50;
    localparam int PHASE_DEG       = 90;
    localparam int FULL_DEG        = 360;
    localparam int DLL_UPDATE_NS   = 320;
    localparam int DLL_UPDATE_CYC  = DLL_UPDATE_NS * CLK_MHZ / 1000;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_SDR, MODE_DDR, MODE_GEAR, MODE_RSVD} io_mode_type;
    typedef enum logic [1:0] {EDGE_LEFT, EDGE_RIGHT, EDGE_TOP, EDGE_BOTTOM} edge_type;
    typedef enum logic [1:0] {RD_IDLE, RD_WAIT_LOW, RD_PREAMBLE, RD_BURST} rd_state_type;
endpackage

// >>> isi_stretch.sv
// Per-pin output history and isolated-bit stretch selection
`timescale 1ns/1ps
`default_nettype none
module isi_stretch
    import ddr_strobe_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rstN,
    input  wire logic             enable,
    input  wire logic [ISI_W-1:0] delaySel,
    input  wire logic             dataIn,
    output logic                  dataOut,
    output logic      [ISI_W-1:0] stretch
);
    logic [1:0] hist_r;
    logic       isolated;

    // Middle bit differs from both neighbours: 010 or 101
    assign isolated = (hist_r[1] != hist_r[0]) && (hist_r[0] != dataIn); // RULE4

    // ------------------------------------------------------------
    // History shift and stretch register
    // ------------------------------------------------------------
    // Long runs never stretch
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            hist_r  <= 2'h0;
            dataOut <= 1'b0;
            stretch <= '0;
        end else begin
            hist_r  <= {hist_r[0], dataIn};
            dataOut <= hist_r[0];
            stretch <= (enable && isolated) ? delaySel : '0; // RULE4 RULE5
        end
    end
endmodule
`default_nettype wire
